// ===== inc/csf_pkg.sv
// Package holding the constants, types and register map of the status flag block.
// Functional notes
// - Status bits 7..5 hold three-bit priority.
// - Core control bit above forms four-bit level.
// - Upper priority bit set blocks user interrupts.
// - Priority bits read-only while nesting disable set.
// - Bit 4 high while repeat loop runs.
// - Bit 3 set on negative result.
// - Bit 2 set on signed overflow.
// - Bit 1 zero flag, set by zero result, cleared by nonzero.
// - Bit 0 carry out, borrow on subtract.
// - Read-or-clear bit: software cannot set it.
package csf_pkg;
    localparam int          CSF_DW            = 16;
    localparam int          CSF_AW            = 8;
    localparam int          CSF_PRI_HI        = 7;
    localparam int          CSF_PRI_LO        = 5;
    localparam int          CSF_LOOP_BIT      = 4;
    localparam int          CSF_NEG_BIT       = 3;
    localparam int          CSF_OVF_BIT       = 2;
    localparam int          CSF_ZERO_BIT      = 1;
    localparam int          CSF_CARRY_BIT     = 0;
    localparam int          CSF_CORE_PRI_BIT  = 3;
    localparam int          CSF_NEST_DIS_BIT  = 15;
    localparam logic [2:0]  CSF_PRI_ALL_ONES  = 3'h7;
    localparam logic [7:0]  CSF_STATUS_OFF    = 8'h00;
    localparam logic [7:0]  CSF_CORE_OFF      = 8'h04;
    localparam logic [7:0]  CSF_INTC1_OFF     = 8'h08;
    localparam logic [7:0]  CSF_LEVEL_OFF     = 8'h0C;
    localparam logic [15:0] CSF_STATUS_RST    = 16'h0000;
    localparam logic [15:0] CSF_CORE_RST      = 16'h0000;
    localparam logic [15:0] CSF_INTC1_RST     = 16'h0000;
    localparam logic [1:0]  CSF_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  CSF_RESP_SLVERR   = 2'h2;

    // Flag update request from the execution datapath.
    typedef struct packed {
        logic        upd_neg;
        logic        upd_ovf;
        logic        upd_zero;
        logic        upd_carry;
        logic        neg;
        logic        ovf;
        logic        nonzero;
        logic        carry;
    } csf_alu_s;
endpackage

// ===== inc/csf_flag_if.sv
// Interface carrying ALU flag updates between the top and the flag register.
`timescale 1ns/100ps
interface csf_flag_if;
    import csf_pkg::*;
    csf_alu_s         alu;
    logic             sw_we;
    logic [7:0]       sw_data;
    logic             pri_lock;
    logic             loop_on;
    logic [7:0]       low_byte;
    modport owner (input alu, input sw_we, input sw_data, input pri_lock, input loop_on,
                   output low_byte);
    modport user  (output alu, output sw_we, output sw_data, output pri_lock,
                   output loop_on, input low_byte);
endinterface

// ===== src/csf_flag_reg.sv
// Lower status byte register: priority field, loop flag and ALU flags.
`timescale 1ns/100ps
module csf_flag_reg (
    input  wire logic  clock,
    input  wire logic  rst,
    csf_flag_if.owner  fl
);
    import csf_pkg::*;

    typedef struct packed {
        logic [7:0] sb;
    } csf_fr_s;

    csf_fr_s st_q;
    csf_fr_s st_d;

    // Hardware flag updates win over software writes in the same cycle.
    always_comb begin
        st_d = st_q;
        if (fl.sw_we) begin
            if (!fl.pri_lock) begin
                st_d.sb[CSF_PRI_HI:CSF_PRI_LO] = fl.sw_data[CSF_PRI_HI:CSF_PRI_LO];
            end
            st_d.sb[CSF_NEG_BIT]   = fl.sw_data[CSF_NEG_BIT];
            st_d.sb[CSF_OVF_BIT]   = fl.sw_data[CSF_OVF_BIT];
            st_d.sb[CSF_ZERO_BIT]  = fl.sw_data[CSF_ZERO_BIT];
            st_d.sb[CSF_CARRY_BIT] = fl.sw_data[CSF_CARRY_BIT];
        end
        if (fl.alu.upd_neg) begin
            st_d.sb[CSF_NEG_BIT] = fl.alu.neg;
        end
        if (fl.alu.upd_ovf) begin
            st_d.sb[CSF_OVF_BIT] = fl.alu.ovf;
        end
        if (fl.alu.upd_zero && fl.alu.nonzero) begin
            st_d.sb[CSF_ZERO_BIT] = 1'b0;
        end else if (fl.alu.upd_zero) begin
            st_d.sb[CSF_ZERO_BIT] = 1'b1;
        end
        if (fl.alu.upd_carry) begin
            st_d.sb[CSF_CARRY_BIT] = fl.alu.carry;
        end
        st_d.sb[CSF_LOOP_BIT] = fl.loop_on;
    end

    // State register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= CSF_STATUS_RST[7:0];
        end else begin
            st_q <= st_d;
        end
    end

    assign fl.low_byte = st_q.sb;

    a_pri_lock_hold: assert property (@(posedge clock) disable iff (rst)
        (fl.pri_lock && !rst) |=> $stable(st_q.sb[CSF_PRI_HI:CSF_PRI_LO]))
        else $error("Priority field changed while locked.");
    a_neg_follow: assert property (@(posedge clock) disable iff (rst)
        fl.alu.upd_neg |=> st_q.sb[CSF_NEG_BIT] == $past(fl.alu.neg))
        else $error("Negative flag did not follow the result.");
    a_ovf_follow: assert property (@(posedge clock) disable iff (rst)
        fl.alu.upd_ovf |=> st_q.sb[CSF_OVF_BIT] == $past(fl.alu.ovf))
        else $error("Overflow flag did not follow the result.");
    a_zero_clear: assert property (@(posedge clock) disable iff (rst)
        (fl.alu.upd_zero && fl.alu.nonzero) |=> !st_q.sb[CSF_ZERO_BIT])
        else $error("Zero flag not cleared by a nonzero result.");
    a_carry_follow: assert property (@(posedge clock) disable iff (rst)
        fl.alu.upd_carry |=> st_q.sb[CSF_CARRY_BIT] == $past(fl.alu.carry))
        else $error("Carry flag did not follow the result.");
    a_loop_track: assert property (@(posedge clock) disable iff (rst)
        ##1 st_q.sb[CSF_LOOP_BIT] == $past(fl.loop_on))
        else $error("Loop flag does not track the loop input.");
    a_flag_hold: assert property (@(posedge clock) disable iff (rst)
        (!fl.alu.upd_carry && !fl.sw_we) |=> $stable(st_q.sb[CSF_CARRY_BIT]))
        else $error("Carry flag changed without cause.");
endmodule // csf_flag_reg

// ===== src/csf_status_top.sv
// Top of the status flag block with its AXI4-Lite register slave.
`timescale 1ns/100ps
module csf_status_top (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire csf_pkg::csf_alu_s       alu_upd,
    input  wire logic                    loop_running_flag,
    output logic [3:0]                   cpu_priority_level,
    output logic                         user_irq_block,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    import csf_pkg::*;

    typedef struct packed {
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [15:0] core_control_word;
        logic [15:0] interrupt_control_one;
        logic [7:0]  status_high;
    } csf_top_s;

    csf_top_s st_q;
    csf_top_s st_d;
    csf_flag_if fl ();

    logic        wr_fire;
    logic        ar_fire;
    logic [15:0] status_word;
    logic [3:0]  level;

    // Returns high when the address selects a mapped register.
    function automatic logic csf_mapped(input logic [7:0] a);
        csf_mapped = (a == CSF_STATUS_OFF) || (a == CSF_CORE_OFF) ||
                     (a == CSF_INTC1_OFF) || (a == CSF_LEVEL_OFF);
    endfunction

    // Merges a 16-bit register with byte-enabled write data.
    function automatic logic [15:0] csf_merge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        csf_merge[7:0]  = s[0] ? d[7:0]  : old[7:0];
        csf_merge[15:8] = s[1] ? d[15:8] : old[15:8];
    endfunction

    // Status word and the four-bit priority level built from its priority field and the core control bit.
    assign status_word = {st_q.status_high, fl.low_byte};
    assign level       = {st_q.core_control_word[CSF_CORE_PRI_BIT],
                          fl.low_byte[CSF_PRI_HI:CSF_PRI_LO]};

    // Handshake readies are combinational from the holding state.
    assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
    assign s_axi_wready  = !st_q.w_held && !st_q.bvalid;
    assign s_axi_arready = !st_q.rvalid;
    assign wr_fire       = st_q.aw_held && st_q.w_held && !st_q.bvalid;
    assign ar_fire       = s_axi_arvalid && s_axi_arready;

    // Software write to the status low byte goes to the flag register.
    assign fl.alu      = alu_upd;
    assign fl.loop_on  = loop_running_flag;
    assign fl.pri_lock = st_q.interrupt_control_one[CSF_NEST_DIS_BIT];
    assign fl.sw_we    = wr_fire && (st_q.aw_addr == CSF_STATUS_OFF) && st_q.w_strb[0];
    assign fl.sw_data  = st_q.w_data[7:0];

    csf_flag_reg u_flag (
        .clock (clock),
        .rst   (rst),
        .fl    (fl)
    );

    // Bus channel tracking, register writes and read data capture.
    always_comb begin
        st_d = st_q;
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_held = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            st_d.aw_held = 1'b0;
            st_d.w_held  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = csf_mapped(st_q.aw_addr) ? CSF_RESP_OKAY : CSF_RESP_SLVERR;
            if (st_q.aw_addr == CSF_STATUS_OFF && st_q.w_strb[1]) begin
                // Upper status byte: read-or-clear, a one never sets it.
                st_d.status_high = st_q.status_high & st_q.w_data[15:8];
            end else if (st_q.aw_addr == CSF_CORE_OFF) begin
                st_d.core_control_word = csf_merge(st_q.core_control_word, st_q.w_data,
                                                   st_q.w_strb);
            end else if (st_q.aw_addr == CSF_INTC1_OFF) begin
                st_d.interrupt_control_one = csf_merge(st_q.interrupt_control_one,
                                                       st_q.w_data, st_q.w_strb);
            end
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (ar_fire) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = csf_mapped(s_axi_araddr) ? CSF_RESP_OKAY : CSF_RESP_SLVERR;
            if (s_axi_araddr == CSF_STATUS_OFF) begin
                st_d.rdata = {16'h0000, status_word};
            end else if (s_axi_araddr == CSF_CORE_OFF) begin
                st_d.rdata = {16'h0000, st_q.core_control_word};
            end else if (s_axi_araddr == CSF_INTC1_OFF) begin
                st_d.rdata = {16'h0000, st_q.interrupt_control_one};
            end else if (s_axi_araddr == CSF_LEVEL_OFF) begin
                st_d.rdata = {27'h0000000, user_irq_block, level};
            end else begin
                st_d.rdata = 32'h00000000;
            end
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '{aw_held: 1'b0, aw_addr: 8'h00, w_held: 1'b0, w_data: 32'h00000000,
                      w_strb: 4'h0, bvalid: 1'b0, bresp: CSF_RESP_OKAY, rvalid: 1'b0,
                      rresp: CSF_RESP_OKAY, rdata: 32'h00000000,
                      core_control_word: CSF_CORE_RST, interrupt_control_one: CSF_INTC1_RST,
                      status_high: CSF_STATUS_RST[15:8]};
        end else begin
            st_q <= st_d;
        end
    end

    // Level and interrupt block outputs.
    assign cpu_priority_level = level;
    assign user_irq_block     = st_q.core_control_word[CSF_CORE_PRI_BIT] ||
        (fl.low_byte[CSF_PRI_HI:CSF_PRI_LO] == CSF_PRI_ALL_ONES);
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp  = st_q.bresp;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rresp  = st_q.rresp;
    assign s_axi_rdata  = st_q.rdata;

    a_upper_blocks: assert property (@(posedge clock) disable iff (rst)
        st_q.core_control_word[CSF_CORE_PRI_BIT] |-> user_irq_block)
        else $error("Upper priority bit did not block user interrupts.");
    a_level_range: assert property (@(posedge clock) disable iff (rst)
        st_q.core_control_word[CSF_CORE_PRI_BIT] |-> cpu_priority_level >= 4'h8)
        else $error("Priority level below eight with upper bit set.");
    a_no_set_high: assert property (@(posedge clock) disable iff (rst)
        ##1 ((status_word[15:8] & ~$past(status_word[15:8])) == 8'h00))
        else $error("Software set a read-or-clear status bit.");
    a_bresp_hold: assert property (@(posedge clock) disable iff (rst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before it was taken.");
endmodule // csf_status_top

// ===== testbench/cpu_status_flags_priority_test.sv
// Self-checking testbench for the status flag and priority block.
`timescale 1ns/100ps
module cpu_status_flags_priority_test;
    import csf_pkg::*;
    logic        clock;
    logic        rst;
    csf_alu_s    alu_upd;
    logic        loop_running_flag;
    logic [3:0]  cpu_priority_level;
    logic        user_irq_block;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] rd;
    int          err_count, n_checks, cycles;

    csf_status_top u_dut (.clock(clock), .rst(rst), .alu_upd(alu_upd),
        .loop_running_flag(loop_running_flag), .cpu_priority_level(cpu_priority_level),
        .user_irq_block(user_irq_block), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Compares a seen value with the expected one and counts both outcomes.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Write with both channels offered together; readiness is sampled mid-cycle.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clock);
            aw_ok = s_axi_awvalid && (s_axi_awready === 1'b1);
            w_ok = s_axi_wvalid && (s_axi_wready === 1'b1);
            b_ok = (s_axi_bvalid === 1'b1);
            r = s_axi_bresp;
            @(posedge clock);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end while (!b_ok);
        s_axi_bready <= 1'b0;
        // One idle edge keeps a following call from raising bready in the same step.
        @(posedge clock);
    endtask

    // Read of one word; data and response are sampled mid-cycle, at the falling edge where rvalid is seen.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok, r_ok;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clock);
            ar_ok = s_axi_arvalid && (s_axi_arready === 1'b1);
            r_ok = (s_axi_rvalid === 1'b1);
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clock);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end while (!r_ok);
        s_axi_rready <= 1'b0;
        // One idle edge keeps a following call from raising rready in the same step.
        @(posedge clock);
    endtask

    // Reads a register and compares its word.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, rd, resp);
        chk(rd, exp);
    endtask

    // Registers come out of reset at their documented values.
    task automatic t_reset();
        rd_chk(CSF_STATUS_OFF, {16'h0000, CSF_STATUS_RST});
        rd_chk(CSF_CORE_OFF, {16'h0000, CSF_CORE_RST});
        rd_chk(CSF_INTC1_OFF, {16'h0000, CSF_INTC1_RST});
        rd_chk(CSF_LEVEL_OFF, 32'h0000_0000);
        $display("reset test done");
    endtask

    // Every priority code with the upper level bit clear and set.
    task automatic t_pri();
        for (int c = 0; c < 2; c++) begin
            axi_wr(CSF_CORE_OFF, 32'(c) << 3, resp);
            for (int i = 0; i < 8; i++) begin
                axi_wr(CSF_STATUS_OFF, 32'(i) << 5, resp);
                @(negedge clock);
                chk(cpu_priority_level, (c * 8) + i);
                chk(user_irq_block, (c == 1) || (i == 7));
                rd_chk(CSF_LEVEL_OFF, ((c == 1) || (i == 7)) * 16 + c * 8 + i);
            end
        end
        axi_wr(CSF_CORE_OFF, 32'h0000_0000, resp);
        $display("priority test done");
    endtask

    // Priority field ignores software while nesting is disabled.
    task automatic t_lock();
        axi_wr(CSF_STATUS_OFF, 32'h0000_00A0, resp);
        axi_wr(CSF_INTC1_OFF, 32'h0000_8000, resp);
        axi_wr(CSF_STATUS_OFF, 32'h0000_0060, resp);
        rd_chk(CSF_STATUS_OFF, 32'h0000_00A0);
        chk(cpu_priority_level, 4'h5);
        axi_wr(CSF_INTC1_OFF, 32'h0000_0000, resp);
        axi_wr(CSF_STATUS_OFF, 32'h0000_0060, resp);
        rd_chk(CSF_STATUS_OFF, 32'h0000_0060);
        $display("lock test done");
    endtask

    // ALU strobes set, clear and hold the four result flags.
    task automatic t_flags();
        logic [7:0] stim [7] = '{8'h88, 8'h44, 8'h20, 8'h11, 8'h02, 8'h22, 8'hF0};
        logic [7:0] exp [7] = '{8'h68, 8'h6C, 8'h6E, 8'h6F, 8'h6F, 8'h6D, 8'h62};
        for (int i = 0; i < 7; i++) begin
            alu_upd <= csf_alu_s'(stim[i]);
            @(posedge clock);
            alu_upd <= '0;
            @(posedge clock);
            rd_chk(CSF_STATUS_OFF, {24'h0,exp[i]});
        end
        $display("flag test done");
    endtask

    // Loop flag follows the sequencer and ignores software.
    task automatic t_loop();
        loop_running_flag <= 1'b1;
        repeat (2) @(posedge clock);
        rd_chk(CSF_STATUS_OFF, 32'h0000_0072);
        loop_running_flag <= 1'b0;
        repeat (2) @(posedge clock);
        axi_wr(CSF_STATUS_OFF, 32'h0000_0072, resp);
        rd_chk(CSF_STATUS_OFF, 32'h0000_0062);
        $display("loop test done");
    endtask

    // Clear-only upper byte cannot be set; unmapped place answers with an error.
    task automatic t_misc();
        axi_wr(CSF_STATUS_OFF, 32'h0000_FF62, resp);
        chk(resp, CSF_RESP_OKAY);
        rd_chk(CSF_STATUS_OFF, 32'h0000_0062);
        axi_wr(8'h10, 32'h0000_FFFF, resp);
        chk(resp, CSF_RESP_SLVERR);
        rd_chk(8'h10, 32'h0000_0000);
        chk(resp, CSF_RESP_SLVERR);
        $display("misc test done");
    endtask

    // Cuts a hang short.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    // Main sequence.
    initial begin
        err_count = 0;
        n_checks = 0;
        cycles = 0;
        rst = 1'b1;
        alu_upd = '0;
        loop_running_flag = 1'b0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_pri();
        t_lock();
        t_flags();
        t_loop();
        t_misc();
        report_and_stop();
    end
endmodule // cpu_status_flags_priority_test
